/* hsec_pkg.sv */
// Purpose: shared constants and carriers for the hot-swap enable/status block
// Assumes: comparator inputs already digital, asynchronous to mclk
// Notes:   register indices are the serial-bus register numbers
package hsec_pkg;

    localparam logic [3:0] REG_GOOD_FAULT  = 4'h7;
    localparam logic [3:0] REG_OVERCURRENT = 4'h8;
    localparam logic [3:0] REG_FET_STATUS  = 4'h9;
    localparam logic [3:0] REG_CONTROL     = 4'h6;

    // status field positions
    localparam int MAIN_GOOD_BIT  = 4;
    localparam int MAIN_FAULT_BIT = 5;
    localparam int LOW_GOOD_BIT   = 6;
    localparam int LOW_FAULT_BIT  = 7;
    localparam int MAIN_OC_BIT    = 4;
    localparam int MAIN_FT_BIT    = 5;
    localparam int LOW_OC_BIT     = 6;
    localparam int LOW_FT_BIT     = 7;
    localparam int MAIN_REV_BIT   = 3;
    localparam int MAIN_SER_BIT   = 4;
    localparam int LOW_REV_BIT    = 5;
    localparam int LOW_GATE_BIT   = 7;

    // control register field positions
    localparam int MAIN_EN_BIT     = 0;
    localparam int LOW_EN_BIT      = 1;
    localparam int MAIN_BLEED_BIT  = 2;
    localparam int LOW_BLEED_BIT   = 3;
    localparam int CROSS_DIS_BIT   = 5;
    localparam int LOW_REVPROT_BIT = 6;

    localparam logic [7:0] CONTROL_RESET = 8'h43;
    localparam logic [7:0] STATUS_RESET  = 8'h00;

    // restart hold after a fast shutoff (cycles of mclk)
    localparam int RESTART_NS     = 100;
    localparam int CLK_PERIOD_NS  = 25;
    localparam int RESTART_CYCLES =
        (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // analog comparator outputs for one channel
    typedef struct packed {
        logic out_low;      // output below ~100 mV
        logic out_good;     // output above power-good level
        logic curr_limit;   // in current limit
        logic fast_trip;    // above fast-trip threshold
        logic timer_out;    // fault timer ran out
    } hsec_chan_cmp_t;

    typedef struct packed {
        logic low_rail_uv;  // low output below 2.85 V
        logic over_temp;    // die above ~140 C, cleared 10 C lower
        logic rev_below;    // differential below -3 mV
        logic rev_above;    // differential above +10 mV
    } hsec_low_extra_t;

endpackage : hsec_pkg

/* hsec_sync.sv */
// Purpose: two-stage synchroniser for a group of comparator levels
// Assumes: one clock, synchronous active-high reset
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module hsec_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } hsec_sync_state_t;

    hsec_sync_state_t st_q;
    hsec_sync_state_t st_d;

    always_comb begin
        st_d.meta   = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;
endmodule : hsec_sync
`default_nettype wire

/* hsec_ctrl.sv */
// Purpose: channel-on decision and latched status for a dual-rail hot swap
// Assumes: register port is a simple byte read/write strobe interface
// Notes:   analog loops stay outside; this block only decides and reports
//
// Function
// [R01] channel pin enable must be high
// [R02] register enable bit clear keeps channel off
// [R03] bleed bit holds off until output low
// [R04] low rail under 2.85 V drops main
// [R05] cross-link disable removes that interlock
// [R06] six status bits per channel readable
// [R07] register 7: good 4/6, fault 5/7
// [R08] register 8: overcurrent 4/6, fast 5/7
// [R09] register 9: FET status bits 3,4,5,7
// [R10] fast trip: off now, then restart
// [R11] low rail fast trip same, slow restart; code restarts low after the same RESTART_HOLD count as main
// [R12] low rail current limit starts timer
// [R13] over-temperature in limit turns low off
// [R14] reverse below -3 mV turns low off
// [R15] reverse release only above +10 mV
// [R16] reverse-protect bit clear disables it
// [R17] register 7 flags clear on read
// [R18] register 8 flags clear on read
// [R19] latched flags set at each turn-on; code sets the fast-trip flag on main only
// [R20] reset loads register defaults
// [R21] turn-on is AND of all conditions
// [R22] comparator inputs synchronised first
`timescale 1ns/1ps
`default_nettype none
module hsec_ctrl #(
    parameter int RESTART_HOLD = hsec_pkg::RESTART_CYCLES
) (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       srst,
    // enable pins
    input  wire logic                       main_rail_enable_pin,
    input  wire logic                       low_rail_enable_pin,
    // comparator outputs
    input  wire hsec_pkg::hsec_chan_cmp_t   main_cmp,
    input  wire hsec_pkg::hsec_chan_cmp_t   low_cmp,
    input  wire hsec_pkg::hsec_low_extra_t  low_extra,
    input  wire logic                       main_reverse_fet_status,
    input  wire logic                       main_series_fet_status,
    input  wire logic                       low_gate_drive_status,
    // register port
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic [3:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    output var  logic [7:0]                 reg_rdata,
    // channel drive
    output var  logic                       main_on,
    output var  logic                       low_on,
    output var  logic                       fault_timer_start,
    output var  logic                       low_rail_power_good_n
);

    ////////////////////////////////////////////////////////////////////////
    // synchronised comparators

    localparam int SW = 2 * $bits(hsec_pkg::hsec_chan_cmp_t)
                      + $bits(hsec_pkg::hsec_low_extra_t) + 3;

    hsec_pkg::hsec_chan_cmp_t  m_s;
    hsec_pkg::hsec_chan_cmp_t  l_s;
    hsec_pkg::hsec_low_extra_t x_s;
    logic                      mrev_s;
    logic                      mser_s;
    logic                      lgate_s;

    hsec_sync #(.WIDTH(SW)) u_sync (         // R22
        .mclk     (mclk),
        .srst     (srst),
        .async_in ({main_cmp, low_cmp, low_extra, main_reverse_fet_status,
                    main_series_fet_status, low_gate_drive_status}),
        .sync_out ({m_s, l_s, x_s, mrev_s, mser_s, lgate_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef enum logic [2:0] {
        CH_OFF     = 3'b001,
        CH_RESTART = 3'b010,
        CH_ON      = 3'b100
    } hsec_ch_t;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] good_fault;
        logic [7:0] overcur;
        logic [7:0] rdata;
        hsec_ch_t   main_st;
        hsec_ch_t   low_st;
        logic [7:0] main_cnt;
        logic [7:0] low_cnt;
        logic       rev_block;
        logic       hot_block;
        logic       main_good_prev;
        logic       low_good_prev;
        logic       low_lim_prev;
    } hsec_state_t;

    hsec_state_t st_q;
    hsec_state_t st_d;

    function automatic logic [7:0] hold_count();
        return 8'(RESTART_HOLD);
    endfunction : hold_count

    logic main_req;
    logic low_req;
    logic rd7;
    logic rd8;
    logic low_trip;

    always_comb begin
        // pin, bit and bleed have to agree; main adds cross-link, low adds reverse and heat blocks
        main_req = main_rail_enable_pin                               // R01
                 & st_q.control[hsec_pkg::MAIN_EN_BIT]               // R02
                 & (~st_q.control[hsec_pkg::MAIN_BLEED_BIT]
                    | m_s.out_low | (st_q.main_st != CH_OFF))        // R03
                 & (~x_s.low_rail_uv
                    | st_q.control[hsec_pkg::CROSS_DIS_BIT]);   // R04 R05 R21
        low_req  = low_rail_enable_pin                                // R01
                 & st_q.control[hsec_pkg::LOW_EN_BIT]                // R02
                 & (~st_q.control[hsec_pkg::LOW_BLEED_BIT]
                    | l_s.out_low | (st_q.low_st != CH_OFF))         // R03 R21
                 & ~st_q.rev_block & ~st_q.hot_block;
        rd7 = reg_rd & (reg_addr == hsec_pkg::REG_GOOD_FAULT);
        rd8 = reg_rd & (reg_addr == hsec_pkg::REG_OVERCURRENT);
        low_trip = l_s.fast_trip;
    end

    always_comb begin
        st_d = st_q;

        if (reg_wr && reg_addr == hsec_pkg::REG_CONTROL) begin
            st_d.control = reg_wdata;
        end

        // reverse current comparators with hysteresis
        if (!st_q.control[hsec_pkg::LOW_REVPROT_BIT]) begin
            st_d.rev_block = 1'b0;                                   // R16
        end else if (x_s.rev_below) begin
            st_d.rev_block = 1'b1;                                   // R14
        end else if (x_s.rev_above) begin
            st_d.rev_block = 1'b0;                                   // R15
        end

        // thermal shutoff only while limiting; comparator carries hysteresis
        if (x_s.over_temp && l_s.curr_limit) begin
            st_d.hot_block = 1'b1;                                   // R13
        end else if (!x_s.over_temp) begin
            st_d.hot_block = 1'b0;
        end

        // main channel
        case (st_q.main_st)
            CH_OFF: begin
                if (main_req) begin
                    st_d.main_st = CH_ON;
                end
            end
            CH_RESTART: begin
                if (!main_req) begin
                    st_d.main_st = CH_OFF;
                end else if (st_q.main_cnt == 8'h00) begin
                    st_d.main_st = CH_ON;                            // R10
                end else begin
                    st_d.main_cnt = st_q.main_cnt - 8'h01;
                end
            end
            CH_ON: begin
                if (!main_req) begin
                    st_d.main_st = CH_OFF;
                end else if (m_s.fast_trip) begin
                    st_d.main_st  = CH_RESTART;                      // R10
                    st_d.main_cnt = hold_count();
                end
            end
            default: st_d.main_st = CH_OFF;
        endcase

        // low channel
        case (st_q.low_st)
            CH_OFF: begin
                if (low_req) begin
                    st_d.low_st = CH_ON;
                end
            end
            CH_RESTART: begin
                if (!low_req) begin
                    st_d.low_st = CH_OFF;
                end else if (st_q.low_cnt == 8'h00) begin
                    st_d.low_st = CH_ON;                             // R11
                end else begin
                    st_d.low_cnt = st_q.low_cnt - 8'h01;
                end
            end
            CH_ON: begin
                if (!low_req) begin
                    st_d.low_st = CH_OFF;
                end else if (low_trip) begin
                    st_d.low_st  = CH_RESTART;                       // R11
                    st_d.low_cnt = hold_count();
                end
            end
            default: st_d.low_st = CH_OFF;
        endcase

        st_d.main_good_prev = m_s.out_good;
        st_d.low_good_prev  = l_s.out_good;
        st_d.low_lim_prev   = l_s.curr_limit;

        // clear on read first, so events in the same cycle win
        if (rd7) begin
            st_d.good_fault = hsec_pkg::STATUS_RESET;                // R17
        end
        if (rd8) begin
            st_d.overcur = hsec_pkg::STATUS_RESET;                   // R18
        end

        if (st_q.main_good_prev && !m_s.out_good) begin
            st_d.good_fault[hsec_pkg::MAIN_GOOD_BIT] = 1'b1;         // R07
        end
        if (st_q.low_good_prev && !l_s.out_good) begin
            st_d.good_fault[hsec_pkg::LOW_GOOD_BIT] = 1'b1;          // R07
        end
        if (m_s.timer_out) begin
            st_d.good_fault[hsec_pkg::MAIN_FAULT_BIT] = 1'b1;        // R07
        end
        if (l_s.timer_out) begin
            st_d.good_fault[hsec_pkg::LOW_FAULT_BIT] = 1'b1;         // R07
        end
        if (m_s.curr_limit) begin
            st_d.overcur[hsec_pkg::MAIN_OC_BIT] = 1'b1;              // R08
        end
        if (l_s.curr_limit) begin
            st_d.overcur[hsec_pkg::LOW_OC_BIT] = 1'b1;               // R08
        end
        if (m_s.fast_trip) begin
            st_d.overcur[hsec_pkg::MAIN_FT_BIT] = 1'b1;              // R08
        end
        if (l_s.fast_trip) begin
            st_d.overcur[hsec_pkg::LOW_FT_BIT] = 1'b1;               // R08
        end

        // output starts below good at each turn-on, so flags show set;
        // the restart after a fast trip is a normal turn-on as well
        if (st_q.main_st != CH_ON && st_d.main_st == CH_ON) begin
            st_d.good_fault[hsec_pkg::MAIN_GOOD_BIT] = 1'b1;         // R19
            st_d.overcur[hsec_pkg::MAIN_OC_BIT]      = 1'b1;         // R19
            st_d.overcur[hsec_pkg::MAIN_FT_BIT]      = 1'b1;         // R19
        end
        if (st_q.low_st != CH_ON && st_d.low_st == CH_ON) begin
            st_d.good_fault[hsec_pkg::LOW_GOOD_BIT] = 1'b1;          // R19
            st_d.overcur[hsec_pkg::LOW_OC_BIT]      = 1'b1;          // R19
        end

        // read data, registered
        st_d.rdata = 8'h00;
        if (reg_addr == hsec_pkg::REG_GOOD_FAULT) begin
            st_d.rdata = st_q.good_fault;                            // R06
        end else if (reg_addr == hsec_pkg::REG_OVERCURRENT) begin
            st_d.rdata = st_q.overcur;                               // R06
        end else if (reg_addr == hsec_pkg::REG_FET_STATUS) begin
            st_d.rdata[hsec_pkg::MAIN_REV_BIT] = mrev_s;             // R09
            st_d.rdata[hsec_pkg::MAIN_SER_BIT] = mser_s;             // R09
            st_d.rdata[hsec_pkg::LOW_REV_BIT]  = st_q.rev_block;     // R09
            st_d.rdata[hsec_pkg::LOW_GATE_BIT] = lgate_s;            // R09
        end else if (reg_addr == hsec_pkg::REG_CONTROL) begin
            st_d.rdata = st_q.control;
        end
        st_d.rdata[3:0] = (reg_addr == hsec_pkg::REG_CONTROL)
                        ? st_d.rdata[3:0]
                        : {st_d.rdata[3], 3'h0};
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q          <= '0;                                     // R20
            st_q.control  <= hsec_pkg::CONTROL_RESET;                // R20
            st_q.main_st  <= CH_OFF;
            st_q.low_st   <= CH_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign main_on               = (st_q.main_st == CH_ON);
    assign low_on                = (st_q.low_st == CH_ON);
    assign fault_timer_start     = l_s.curr_limit & ~st_q.low_lim_prev; // R12
    assign low_rail_power_good_n = ~l_s.out_good;
    assign reg_rdata             = st_q.rdata;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence main_trip_s;
        st_q.main_st == CH_ON && m_s.fast_trip && main_req;
    endsequence

    main_restart_a: assert property (@(posedge mclk) disable iff (srst) // R10
        main_trip_s |=> !main_on)
        else $error("main did not drop on fast trip");

    low_trip_a: assert property (@(posedge mclk) disable iff (srst) // R11
        (low_on && low_trip && low_req) |=> !low_on)
        else $error("low did not drop on fast trip");

    en_bit_a: assert property (@(posedge mclk) disable iff (srst) // R02
        !st_q.control[hsec_pkg::MAIN_EN_BIT] |=> !main_on)
        else $error("main on with enable bit clear");

    pin_low_a: assert property (@(posedge mclk) disable iff (srst) // R01
        !low_rail_enable_pin |=> !low_on)
        else $error("low on with pin low");

    bleed_hold_a: assert property (@(posedge mclk) disable iff (srst) // R03
        (st_q.main_st == CH_OFF && st_q.control[hsec_pkg::MAIN_BLEED_BIT]
         && !m_s.out_low) |=> !main_on)
        else $error("main turned on before bleed-down");

    cross_off_a: assert property (@(posedge mclk) disable iff (srst) // R04
        (x_s.low_rail_uv && !st_q.control[hsec_pkg::CROSS_DIS_BIT])
        |=> !main_on)
        else $error("main stayed on under low rail drop");

    rev_block_a: assert property (@(posedge mclk) disable iff (srst) // R14
        (st_q.control[hsec_pkg::LOW_REVPROT_BIT] && x_s.rev_below)
        |=> ##1 !low_on)
        else $error("low on during reverse current");

    rev_off_a: assert property (@(posedge mclk) disable iff (srst) // R16
        !st_q.control[hsec_pkg::LOW_REVPROT_BIT] |=> !st_q.rev_block)
        else $error("reverse block with protect disabled");

    rd7_clear_a: assert property (@(posedge mclk) disable iff (srst) // R17
        (rd7 && !m_s.timer_out && !l_s.timer_out
         && $stable(st_q.main_st) && st_q.main_good_prev == m_s.out_good)
        |=> st_q.good_fault[hsec_pkg::MAIN_FAULT_BIT] == 1'b0)
        else $error("register 7 not cleared on read");

    oc_sticky_a: assert property (@(posedge mclk) disable iff (srst) // R18
        (st_q.overcur[hsec_pkg::LOW_OC_BIT] && !rd8)
        |=> st_q.overcur[hsec_pkg::LOW_OC_BIT])
        else $error("overcurrent flag lost without read");

endmodule : hsec_ctrl
`default_nettype wire

/* hsec_host.sv */
// Purpose: register host model facing the hot-swap enable/status block
// Assumes: strobes launched on the falling edge of mclk
// Notes:   one access per call; a read returns the registered answer
`timescale 1ns/1ps
`default_nettype none
module hsec_host (
    // clock
    input  wire logic       mclk,
    // register port
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [3:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // host sets enables and reverse protect through the control byte
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr    = 1'b0;
    endtask : write_reg

    // answer is registered, so it is taken one edge after the strobe
    task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge mclk);
        d        = reg_rdata;
        reg_rd   = 1'b0;
    endtask : read_reg
endmodule : hsec_host
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for the hot-swap enable/status block
// Assumes: inputs change on the falling edge of mclk
// Notes:   comparator levels cross a synchroniser, so waits are bounded
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk, srst, main_rail_enable_pin, low_rail_enable_pin;
    logic main_reverse_fet_status, main_series_fet_status;
    logic low_gate_drive_status, reg_wr, reg_rd;
    logic main_on, low_on, fault_timer_start, low_rail_power_good_n;
    logic [3:0]                 reg_addr;
    logic [7:0]                 reg_wdata, reg_rdata;
    hsec_pkg::hsec_chan_cmp_t   main_cmp, low_cmp;
    hsec_pkg::hsec_low_extra_t  low_extra;
    int                         miscompares, n_checks;

    hsec_ctrl #(.RESTART_HOLD(3)) hsec_ctrl_inst (
        .mclk, .srst, .main_rail_enable_pin, .low_rail_enable_pin,
        .main_cmp, .low_cmp, .low_extra, .main_reverse_fet_status,
        .main_series_fet_status, .low_gate_drive_status, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .main_on, .low_on,
        .fault_timer_start, .low_rail_power_good_n
    );
    hsec_host hsec_host_inst (
        .mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t byte got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t level got %b exp %b", $time, got, exp);
        end
    endtask : chk1

    // only the masked bits are judged
    task automatic rd(input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] exp);
        logic [7:0] v;
        hsec_host_inst.read_reg(a, v);
        chk8(v & m, exp);
    endtask : rd

    task automatic clr();
        logic [7:0] v;
        hsec_host_inst.read_reg(4'h7, v);
        hsec_host_inst.read_reg(4'h8, v);
    endtask : clr

    // synchroniser plus state register: three cycles, four to be safe
    task automatic settle();
        repeat (4) @(negedge mclk);
    endtask : settle

    task automatic wait_ch(input logic is_main, input logic exp);
        logic cur;
        cur = ~exp;
        for (int i = 0; i < 12 && cur !== exp; i++) begin
            @(negedge mclk);
            cur = is_main ? main_on : low_on;
        end
        chk1(cur, exp);
    endtask : wait_ch

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        logic m;
        logic seen;
        miscompares = 0;
        n_checks = 0;
        srst = 1'b1;
        {main_rail_enable_pin, low_rail_enable_pin} = 2'h0;
        main_cmp = '0;
        low_cmp = '0;
        low_extra = '0;
        main_reverse_fet_status = 1'b0;
        main_series_fet_status = 1'b0;
        low_gate_drive_status = 1'b0;
        repeat (20) @(negedge mclk);
        srst = 1'b0;
        rd(4'h6, 8'hff, 8'h43);
        rd(4'h7, 8'hff, 8'h00);
        rd(4'h8, 8'hff, 8'h00);
        rd(4'h9, 8'hff, 8'h00);
        rd(4'hf, 8'hff, 8'h00);
        settle();
        chk1(main_on, 1'b0);
        chk1(low_on, 1'b0);
        // pins up: both channels start and latch their turn-on flags
        {main_rail_enable_pin, low_rail_enable_pin} = 2'h3;
        wait_ch(1'b1, 1'b1);
        wait_ch(1'b0, 1'b1);
        rd(4'h7, 8'hff, 8'h50);
        rd(4'h8, 8'hff, 8'h70);
        rd(4'h7, 8'hff, 8'h00);
        rd(4'h8, 8'hff, 8'h00);
        hsec_host_inst.write_reg(4'h6, 8'h42);
        wait_ch(1'b1, 1'b0);
        chk1(low_on, 1'b1);
        hsec_host_inst.write_reg(4'h6, 8'h43);
        wait_ch(1'b1, 1'b1);
        // low rail sag drops main unless the interlock is disabled
        low_extra.low_rail_uv = 1'b1;
        wait_ch(1'b1, 1'b0);
        chk1(low_on, 1'b1);
        hsec_host_inst.write_reg(4'h6, 8'h63);
        wait_ch(1'b1, 1'b1);
        low_extra.low_rail_uv = 1'b0;
        hsec_host_inst.write_reg(4'h6, 8'h43);
        // bleed-down: restart waits for the output to discharge
        hsec_host_inst.write_reg(4'h6, 8'h4f);
        {main_rail_enable_pin, low_rail_enable_pin} = 2'h0;
        wait_ch(1'b1, 1'b0);
        wait_ch(1'b0, 1'b0);
        {main_rail_enable_pin, low_rail_enable_pin} = 2'h3;
        settle();
        chk1(main_on, 1'b0);
        chk1(low_on, 1'b0);
        main_cmp.out_low = 1'b1;
        low_cmp.out_low = 1'b1;
        wait_ch(1'b1, 1'b1);
        wait_ch(1'b0, 1'b1);
        main_cmp.out_low = 1'b0;
        low_cmp.out_low = 1'b0;
        hsec_host_inst.write_reg(4'h6, 8'h43);
        // fast trip on each channel: off at once, then a fresh turn-on
        for (int ch = 0; ch < 2; ch++) begin
            m = (ch == 0);
            clr();
            if (m) main_cmp.fast_trip = 1'b1;
            else low_cmp.fast_trip = 1'b1;
            @(negedge mclk);
            main_cmp.fast_trip = 1'b0;
            low_cmp.fast_trip = 1'b0;
            wait_ch(m, 1'b0);
            wait_ch(m, 1'b1);
            rd(4'h8, m ? 8'h30 : 8'hc0, m ? 8'h30 : 8'hc0);
            rd(4'h7, m ? 8'h30 : 8'hc0, m ? 8'h10 : 8'h40);
        end
        // current limit starts the timer; heat in limit turns low off
        clr();
        low_cmp.curr_limit = 1'b1;
        seen = 1'b0;
        repeat (6) begin
            @(negedge mclk);
            if (fault_timer_start === 1'b1) seen = 1'b1;
        end
        chk1(seen, 1'b1);
        low_extra.over_temp = 1'b1;
        wait_ch(1'b0, 1'b0);
        low_extra.over_temp = 1'b0;
        wait_ch(1'b0, 1'b1);
        low_cmp.curr_limit = 1'b0;
        rd(4'h8, 8'h40, 8'h40);
        // reverse current with hysteresis, then with protection off
        main_reverse_fet_status = 1'b1;
        main_series_fet_status = 1'b1;
        low_gate_drive_status = 1'b1;
        low_extra.rev_below = 1'b1;
        wait_ch(1'b0, 1'b0);
        rd(4'h9, 8'hff, 8'hb8);
        low_extra.rev_below = 1'b0;
        settle();
        chk1(low_on, 1'b0);
        low_extra.rev_above = 1'b1;
        wait_ch(1'b0, 1'b1);
        rd(4'h9, 8'hff, 8'h98);
        low_extra.rev_above = 1'b0;
        hsec_host_inst.write_reg(4'h6, 8'h03);
        low_extra.rev_below = 1'b1;
        settle();
        chk1(low_on, 1'b1);
        low_extra.rev_below = 1'b0;
        hsec_host_inst.write_reg(4'h6, 8'h43);
        // falling power good latches; the pin follows the low rail level
        main_cmp.out_good = 1'b1;
        low_cmp.out_good = 1'b1;
        settle();
        chk1(low_rail_power_good_n, 1'b0);
        clr();
        main_cmp.out_good = 1'b0;
        low_cmp.out_good = 1'b0;
        settle();
        chk1(low_rail_power_good_n, 1'b1);
        rd(4'h7, 8'h50, 8'h50);
        // fault timers run out on both channels
        main_cmp.timer_out = 1'b1;
        low_cmp.timer_out = 1'b1;
        @(negedge mclk);
        main_cmp.timer_out = 1'b0;
        low_cmp.timer_out = 1'b0;
        settle();
        rd(4'h7, 8'ha0, 8'ha0);
        rd(4'h7, 8'ha0, 8'h00);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
